// File: include/usic_map.vh
// Purpose: Register map and constants of the serial status/control block
// Assumes: 16-bit register words on a plain strobe port
// Notes: Included by the transceiver status/control logic
`ifndef USIC_MAP_VH
`define USIC_MAP_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define USIC_ADDR_W 3
`define USIC_ADDR_STA 3'h0
`define USIC_ADDR_TXDATA 3'h1
`define USIC_ADDR_RXDATA 3'h2
`define USIC_ADDR_IRQ_STAT 3'h3
`define USIC_ADDR_IRQ_MASK 3'h4

// ----------------------------------------
// Status/control field positions
// ----------------------------------------
`define USIC_TXISEL1 15
`define USIC_TXINV 14
`define USIC_TXISEL0 13
`define USIC_TXBRK 11
`define USIC_TXEN 10
`define USIC_TXBF 9
`define USIC_TX_IDLE_FLAG 8
`define USIC_RXISEL_HI 7
`define USIC_RXISEL_LO 6
`define USIC_INFRARED_ENCODE_ENABLE 5
`define USIC_STA_WMASK 16'hECE0
`define USIC_STA_RESET 16'h0000

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define USIC_IRQ_TX 0
`define USIC_IRQ_RX 1
`define USIC_IRQ_W 2

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define USIC_TXBUF_DEPTH 4
`define USIC_RXBUF_DEPTH 4
`define USIC_BREAK_ZEROS 12
`define USIC_BIT_CYCLES 16'h0010
`define USIC_SYNC_STAGES 2

`endif

// File: verilog/usic_bit_timer.v
// Purpose: Bit period tick generator for the transmit shifter
// Assumes: One clock domain
// Notes: Restarts while held clear
`timescale 1ns/1ns
`default_nettype none
`include "usic_map.vh"

module usic_bit_timer (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Control
   input wire run,
   input wire [15:0] period,
   // Tick
   output reg tick
);

   reg [15:0] count_reg;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count_reg <= 16'h0000;
         tick <= 1'b0;
      end else if (!run) begin
         // Preload so the first period after start is as long as the rest
         count_reg <= 16'h0001;
         tick <= 1'b0;
      end else if (count_reg == period - 16'h0001) begin
         count_reg <= 16'h0000;
         tick <= 1'b1;
      end else begin
         count_reg <= count_reg + 16'h0001;
         tick <= 1'b0;
      end
   end

endmodule // usic_bit_timer
`default_nettype wire

// File: verilog/usic_status_control.v
// Purpose: Status/control register and transmit/receive framing of a serial transceiver
// Assumes: Plain strobe register port; receive line from a pin
// Notes: 8N1 framing, fixed bit period, four-deep buffers each way
//
// Overview of operation
// - Select 10: irq when buffer empties into shifter
// - Select 01: irq after last character shifted out
// - Select 00: irq on every character load into shifter
// - Plain mode: invert bit set gives idle low
// - Infrared mode: invert bit set gives idle high
// - Break request sends start, twelve zeros, stop
// - Hardware clears break request when break completes
// - Transmit enable hands pin to the transceiver
// - Clearing enable aborts transfer and resets buffer
// - Buffer full flag reports no free slot
// - Idle flag: shifter and buffer both empty
// - Receive select 11: irq at four characters
// - Receive select 10: irq at three characters
// - Receive select 0x: irq on every character
// - Bit 12 always reads zero
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "usic_map.vh"

module usic_status_control (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Register port
   input wire [`USIC_ADDR_W-1:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // Serial pins
   input wire serial_rx_pin,
   output reg serial_tx_pin,
   output wire tx_pin_owned,
   // Interrupt
   output wire irq
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   reg [1:0] tx_irq_select_reg;
   reg tx_polarity_invert_reg;
   reg tx_break_request_reg;
   reg tx_enable_bit_reg;
   reg [1:0] rx_irq_select_reg;
   reg infrared_encode_enable_reg;
   reg [`USIC_IRQ_W-1:0] irq_stat_reg;
   reg [`USIC_IRQ_W-1:0] irq_mask_reg;

   // Transmit buffer
   reg [7:0] txbuf_mem [0:`USIC_TXBUF_DEPTH-1];
   reg [1:0] txbuf_wp_reg;
   reg [1:0] txbuf_rp_reg;
   reg [2:0] txbuf_cnt_reg;

   // Receive buffer
   reg [7:0] rxbuf_mem [0:`USIC_RXBUF_DEPTH-1];
   reg [1:0] rxbuf_wp_reg;
   reg [1:0] rxbuf_rp_reg;
   reg [2:0] rxbuf_cnt_reg;

   // Transmit shifter
   localparam TX_IDLE = 2'd0;
   localparam TX_SHIFT = 2'd1;
   reg [1:0] tx_state_reg;
   reg [13:0] tx_shift_reg;
   reg [3:0] tx_bits_reg;
   reg tx_is_break_reg;
   reg tx_line_reg;

   // Receive shifter
   localparam RX_IDLE = 2'd0;
   localparam RX_START = 2'd1;
   localparam RX_DATA = 2'd2;
   localparam RX_STOP = 2'd3;
   reg [1:0] rx_state_reg;
   reg [7:0] rx_shift_reg;
   reg [3:0] rx_bits_reg;
   reg [15:0] rx_cnt_reg;
   reg rx_sync1_reg;
   reg rx_sync2_reg;

   wire tx_tick;
   wire tx_full;
   wire tx_empty;
   wire tx_load;
   wire tx_done;
   wire tx_buf_wr;
   wire rx_push;
   wire rx_pop;
   wire [2:0] rx_cnt_after;
   reg tx_irq_event;
   reg rx_irq_event;
   wire [15:0] sta_value;

   // Field decode used by several paths
   function is_wr;
      input [`USIC_ADDR_W-1:0] a;
      input [`USIC_ADDR_W-1:0] target;
      input w;
      begin
         is_wr = w && (a == target);
      end
   endfunction

   // ----------------------------------------
   // Bit timer
   // ----------------------------------------
   usic_bit_timer u_tx_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .run(tx_state_reg == TX_SHIFT),
      .period(`USIC_BIT_CYCLES),
      .tick(tx_tick)
   );

   // ----------------------------------------
   // Buffer flags
   // ----------------------------------------
   assign tx_full = (txbuf_cnt_reg == 3'd4);
   assign tx_empty = (txbuf_cnt_reg == 3'd0);
   assign tx_buf_wr = is_wr(reg_addr, `USIC_ADDR_TXDATA, reg_wr) && !tx_full && tx_enable_bit_reg;
   assign tx_load = tx_enable_bit_reg && (tx_state_reg == TX_IDLE) &&
      (tx_break_request_reg || !tx_empty);
   assign tx_done = (tx_state_reg == TX_SHIFT) && tx_tick && (tx_bits_reg == 4'd0);
   assign rx_pop = reg_rd && (reg_addr == `USIC_ADDR_RXDATA) && (rxbuf_cnt_reg != 3'd0);

   // ----------------------------------------
   // Status/control register
   // ----------------------------------------
   assign sta_value = {tx_irq_select_reg[1], tx_polarity_invert_reg, tx_irq_select_reg[0],
      1'b0,
      tx_break_request_reg, tx_enable_bit_reg, tx_full,
      tx_empty && (tx_state_reg == TX_IDLE),
      rx_irq_select_reg, infrared_encode_enable_reg, 5'b00000};

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_irq_select_reg <= 2'b00;
         tx_polarity_invert_reg <= 1'b0;
         tx_break_request_reg <= 1'b0;
         tx_enable_bit_reg <= 1'b0;
         rx_irq_select_reg <= 2'b00;
         infrared_encode_enable_reg <= 1'b0;
         irq_mask_reg <= 2'b00;
      end else begin
         if (is_wr(reg_addr, `USIC_ADDR_STA, reg_wr)) begin
            tx_irq_select_reg <= {reg_wdata[`USIC_TXISEL1], reg_wdata[`USIC_TXISEL0]};
            tx_polarity_invert_reg <= reg_wdata[`USIC_TXINV];
            tx_enable_bit_reg <= reg_wdata[`USIC_TXEN];
            rx_irq_select_reg <= reg_wdata[`USIC_RXISEL_HI:`USIC_RXISEL_LO];
            infrared_encode_enable_reg <= reg_wdata[`USIC_INFRARED_ENCODE_ENABLE];
         end
         if (is_wr(reg_addr, `USIC_ADDR_STA, reg_wr) && reg_wdata[`USIC_TXBRK])
            tx_break_request_reg <= 1'b1;
         else if (tx_done && tx_is_break_reg)
            tx_break_request_reg <= 1'b0;
         else if (!tx_enable_bit_reg)
            tx_break_request_reg <= 1'b0;
         if (is_wr(reg_addr, `USIC_ADDR_IRQ_MASK, reg_wr))
            irq_mask_reg <= reg_wdata[`USIC_IRQ_W-1:0];
      end
   end

   // ----------------------------------------
   // Transmit buffer
   // ----------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txbuf_wp_reg <= 2'd0;
         txbuf_rp_reg <= 2'd0;
         txbuf_cnt_reg <= 3'd0;
      end else if (!tx_enable_bit_reg) begin
         txbuf_wp_reg <= 2'd0;
         txbuf_rp_reg <= 2'd0;
         txbuf_cnt_reg <= 3'd0;
      end else begin
         if (tx_buf_wr)
            txbuf_wp_reg <= txbuf_wp_reg + 2'd1;
         if (tx_load && !tx_break_request_reg)
            txbuf_rp_reg <= txbuf_rp_reg + 2'd1;
         if (tx_buf_wr && !(tx_load && !tx_break_request_reg))
            txbuf_cnt_reg <= txbuf_cnt_reg + 3'd1;
         else if (!tx_buf_wr && tx_load && !tx_break_request_reg)
            txbuf_cnt_reg <= txbuf_cnt_reg - 3'd1;
      end
   end

   always @(posedge clk_sys) begin
      if (tx_buf_wr)
         txbuf_mem[txbuf_wp_reg] <= reg_wdata[7:0];
   end

   // ----------------------------------------
   // Transmit shifter
   // ----------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 14'h3FFF;
         tx_bits_reg <= 4'd0;
         tx_is_break_reg <= 1'b0;
      end else if (!tx_enable_bit_reg) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 14'h3FFF;
         tx_bits_reg <= 4'd0;
         tx_is_break_reg <= 1'b0;
      end else begin
         case (tx_state_reg)
            TX_IDLE: begin
               if (tx_load && tx_break_request_reg) begin
                  tx_shift_reg <= {1'b1, 13'h0000};
                  tx_bits_reg <= 4'd13;
                  tx_is_break_reg <= 1'b1;
                  tx_state_reg <= TX_SHIFT;
               end else if (tx_load) begin
                  tx_shift_reg <= {5'b11111, txbuf_mem[txbuf_rp_reg], 1'b0};
                  tx_bits_reg <= 4'd9;
                  tx_is_break_reg <= 1'b0;
                  tx_state_reg <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (tx_tick) begin
                  tx_shift_reg <= {1'b1, tx_shift_reg[13:1]};
                  if (tx_bits_reg == 4'd0)
                     tx_state_reg <= TX_IDLE;
                  else
                     tx_bits_reg <= tx_bits_reg - 4'd1;
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Transmit pin encoding
   // ----------------------------------------
   always @* begin
      tx_line_reg = tx_shift_reg[0];
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         serial_tx_pin <= 1'b1;
      else if (infrared_encode_enable_reg)
         // Pulse only on zero bits; idle level follows invert bit
         serial_tx_pin <= (tx_state_reg == TX_SHIFT && !tx_line_reg) ?
            !tx_polarity_invert_reg : tx_polarity_invert_reg;
      else
         serial_tx_pin <= tx_line_reg ^ tx_polarity_invert_reg;
   end

   assign tx_pin_owned = tx_enable_bit_reg;

   // ----------------------------------------
   // Receive shifter
   // ----------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_sync1_reg <= 1'b1;
         rx_sync2_reg <= 1'b1;
      end else begin
         rx_sync1_reg <= serial_rx_pin;
         rx_sync2_reg <= rx_sync1_reg;
      end
   end

   assign rx_push = (rx_state_reg == RX_STOP) && (rx_cnt_reg == `USIC_BIT_CYCLES - 16'h0001) &&
      rx_sync2_reg && (rxbuf_cnt_reg != 3'd4);

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_state_reg <= RX_IDLE;
         rx_shift_reg <= 8'h00;
         rx_bits_reg <= 4'd0;
         rx_cnt_reg <= 16'h0000;
      end else begin
         case (rx_state_reg)
            RX_IDLE: begin
               rx_cnt_reg <= 16'h0000;
               if (!rx_sync2_reg)
                  rx_state_reg <= RX_START;
            end
            RX_START: begin
               if (rx_cnt_reg == (`USIC_BIT_CYCLES >> 1)) begin
                  rx_cnt_reg <= 16'h0000;
                  rx_bits_reg <= 4'd0;
                  rx_state_reg <= rx_sync2_reg ? RX_IDLE : RX_DATA;
               end else
                  rx_cnt_reg <= rx_cnt_reg + 16'h0001;
            end
            RX_DATA: begin
               if (rx_cnt_reg == `USIC_BIT_CYCLES - 16'h0001) begin
                  rx_cnt_reg <= 16'h0000;
                  rx_shift_reg <= {rx_sync2_reg, rx_shift_reg[7:1]};
                  if (rx_bits_reg == 4'd7)
                     rx_state_reg <= RX_STOP;
                  else
                     rx_bits_reg <= rx_bits_reg + 4'd1;
               end else
                  rx_cnt_reg <= rx_cnt_reg + 16'h0001;
            end
            RX_STOP: begin
               if (rx_cnt_reg == `USIC_BIT_CYCLES - 16'h0001)
                  rx_state_reg <= RX_IDLE;
               else
                  rx_cnt_reg <= rx_cnt_reg + 16'h0001;
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Receive buffer
   // ----------------------------------------
   assign rx_cnt_after = rx_pop ? rxbuf_cnt_reg : rxbuf_cnt_reg + 3'd1;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rxbuf_wp_reg <= 2'd0;
         rxbuf_rp_reg <= 2'd0;
         rxbuf_cnt_reg <= 3'd0;
      end else begin
         if (rx_push)
            rxbuf_wp_reg <= rxbuf_wp_reg + 2'd1;
         if (rx_pop)
            rxbuf_rp_reg <= rxbuf_rp_reg + 2'd1;
         if (rx_push && !rx_pop)
            rxbuf_cnt_reg <= rxbuf_cnt_reg + 3'd1;
         else if (!rx_push && rx_pop)
            rxbuf_cnt_reg <= rxbuf_cnt_reg - 3'd1;
      end
   end

   always @(posedge clk_sys) begin
      if (rx_push)
         rxbuf_mem[rxbuf_wp_reg] <= rx_shift_reg;
   end

   // ----------------------------------------
   // Interrupt events
   // ----------------------------------------
   always @* begin
      case (tx_irq_select_reg)
         2'b10: tx_irq_event = tx_load && !tx_break_request_reg &&
            (txbuf_cnt_reg == 3'd1) && !tx_buf_wr;
         2'b01: tx_irq_event = tx_done && tx_empty && !tx_buf_wr;
         2'b00: tx_irq_event = tx_load && !tx_break_request_reg;
         default: tx_irq_event = 1'b0;
      endcase
   end

   always @* begin
      if (rx_irq_select_reg == 2'b11)
         rx_irq_event = rx_push && (rx_cnt_after == 3'd4);
      else if (rx_irq_select_reg == 2'b10)
         rx_irq_event = rx_push && (rx_cnt_after == 3'd3);
      else
         rx_irq_event = rx_push;
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         irq_stat_reg <= 2'b00;
      else if (is_wr(reg_addr, `USIC_ADDR_IRQ_STAT, reg_wr))
         irq_stat_reg <= (irq_stat_reg & ~reg_wdata[`USIC_IRQ_W-1:0]) |
            {rx_irq_event, tx_irq_event};
      else
         irq_stat_reg <= irq_stat_reg | {rx_irq_event, tx_irq_event};
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (reg_rd) begin
         if (reg_addr == `USIC_ADDR_STA)
            reg_rdata <= sta_value;
         else if (reg_addr == `USIC_ADDR_RXDATA)
            reg_rdata <= {8'h00, rxbuf_mem[rxbuf_rp_reg] & {8{rxbuf_cnt_reg != 3'd0}}};
         else if (reg_addr == `USIC_ADDR_IRQ_STAT)
            reg_rdata <= {14'h0000, irq_stat_reg};
         else if (reg_addr == `USIC_ADDR_IRQ_MASK)
            reg_rdata <= {14'h0000, irq_mask_reg};
         else
            reg_rdata <= 16'h0000;
      end else
         reg_rdata <= 16'h0000;
   end

endmodule // usic_status_control
`default_nettype wire

// File: verification/usic_status_control_sva.sv
// Purpose: Port assertions of the serial status/control block
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
`include "usic_map.vh"

module usic_sc_sva (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Register port
   input wire [`USIC_ADDR_W-1:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   // Serial pins and interrupt
   input wire serial_rx_pin,
   input wire serial_tx_pin,
   input wire tx_pin_owned,
   input wire irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire sta_rd = reg_rd && (reg_addr == `USIC_ADDR_STA);
   wire sta_wr = reg_wr && (reg_addr == `USIC_ADDR_STA);

   rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside answer");
   bit12_zero_a: assert property (sta_rd |=> !reg_rdata[12])
      else $error("status bit 12 not zero");
   en_owns_pin_a: assert property (sta_wr && reg_wdata[`USIC_TXEN] |=> tx_pin_owned)
      else $error("pin not taken after enable");
   dis_frees_pin_a: assert property (sta_wr && !reg_wdata[`USIC_TXEN] |=> !tx_pin_owned)
      else $error("pin kept after disable");
   owner_read_a: assert property (sta_rd |=> reg_rdata[`USIC_TXEN] == $past(tx_pin_owned))
      else $error("enable bit and pin owner differ");
   full_not_idle_a: assert property (sta_rd ##1 reg_rdata[`USIC_TXBF] |-> !reg_rdata[`USIC_TX_IDLE_FLAG])
      else $error("full and idle together");
   off_idle_a: assert property (sta_rd && !tx_pin_owned && !$past(tx_pin_owned)
      |=> reg_rdata[`USIC_TX_IDLE_FLAG] && !reg_rdata[`USIC_TXBF])
      else $error("disabled transmitter not empty");
   idle_level_a: assert property (sta_rd ##1 (reg_rdata[`USIC_TX_IDLE_FLAG] && reg_rdata[`USIC_TXEN]
      && !reg_rdata[`USIC_TXBRK]) |-> serial_tx_pin == (reg_rdata[`USIC_TXINV] ~^ reg_rdata[`USIC_INFRARED_ENCODE_ENABLE]))
      else $error("wrong idle level");
   irq_masked_a: assert property (reg_wr && reg_addr == `USIC_ADDR_IRQ_MASK && reg_wdata[1:0] == 2'b00
      |=> !irq [*2])
      else $error("interrupt with all sources masked");

   cover property (sta_rd ##1 reg_rdata[`USIC_TXBF]);
   cover property ($rose(irq));
   cover property (sta_wr && reg_wdata[`USIC_TXBRK]);
endmodule // usic_sc_sva

bind usic_status_control usic_sc_sva u_sva (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
   .tx_pin_owned(tx_pin_owned), .irq(irq));
`default_nettype wire

// File: verification/usic_remote_peer.sv
// Purpose: Remote serial device on the transmit and receive lines
// Assumes: 8N1 frames, 16 clocks a bit, line idle high
// Notes: Frames without a high stop bit are dropped
`timescale 1ns/1ns
`default_nettype none

module usic_remote_peer (
   // Clock
   input wire logic clk_sys,
   // Serial lines
   input wire logic line_in,
   output var logic line_out
);
   logic [7:0] got_q[$];
   int n_got = 0;
   logic [7:0] sh;

   // Receiver: sample each bit in its middle
   initial begin
      line_out = 1'b1;
      forever begin
         @(posedge clk_sys);
         if (!line_in) begin
            repeat (8) @(posedge clk_sys);
            for (int i = 0; i < 9; i++) begin
               repeat (16) @(posedge clk_sys);
               if (i < 8) sh[i] = line_in;
            end
            if (line_in) begin
               got_q.push_back(sh);
               n_got++;
            end else begin
               wait (line_in);
            end
         end
      end
   end

   // Transmitter: start, eight data bits LSB first, stop
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out <= fr[i];
         repeat (16) @(posedge clk_sys);
      end
   endtask
endmodule // usic_remote_peer
`default_nettype wire

// File: verification/tb.sv
// Purpose: Self-checking bench of the serial status/control block
// Assumes: 10 MHz clock, remote peer on both serial lines
// Notes: Random bytes from a fixed seed, corner bytes first
`timescale 1ns/1ns
`default_nettype none
`include "usic_map.vh"

module tb;
   logic clk_sys, rst, reg_wr, reg_rd;
   logic [`USIC_ADDR_W-1:0] reg_addr;
   logic [15:0] reg_wdata, rv;
   wire [15:0] reg_rdata;
   wire serial_rx_pin, serial_tx_pin, tx_pin_owned, irq, line_tx;
   int n_mismatch = 0;
   int check_count = 0;
   int low_run = 0;
   int max_low = 0;
   logic [7:0] b;
   logic [7:0] sent_q[$];
   logic [1:0] tx_codes[3] = '{2'b00, 2'b10, 2'b01};

   // Port logic holds the line high while the transceiver lets go
   assign line_tx = tx_pin_owned ? serial_tx_pin : 1'b1;

   usic_status_control DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
      .tx_pin_owned(tx_pin_owned), .irq(irq));
   usic_remote_peer peer (.clk_sys(clk_sys), .line_in(line_tx), .line_out(serial_rx_pin));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Longest low stretch on the transmit pin
   always @(negedge clk_sys) begin
      low_run = serial_tx_pin ? 0 : low_run + 1;
      if (low_run > max_low) max_low = low_run;
   end

   task automatic wr(input logic [`USIC_ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [`USIC_ADDR_W-1:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wait_rx(input int n);
      for (int k = 0; k < 4000 && peer.n_got < n; k++) @(posedge clk_sys);
      repeat (16) @(negedge clk_sys);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   function automatic logic exp_tx_irq(input logic [1:0] code, input int ph);
      case (code)
         2'b00: return ph != 2;
         2'b10: return ph == 1;
         default: return ph == 2;
      endcase
   endfunction

   function automatic logic exp_rx_irq(input logic [1:0] code, input int n);
      return !code[1] || (n == (code[0] ? 4 : 3));
   endfunction

   initial begin
      repeat (50000) @(posedge clk_sys);
      n_mismatch++;
      give_verdict;
   end

   initial begin
      rst = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      void'($urandom(74));
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      rd(`USIC_ADDR_STA, rv);
      chk("status reset", rv, 16'h0100);
      rd(3'h6, rv);
      chk("unmapped read", rv, 16'h0000);
      wr(`USIC_ADDR_STA, 16'h74E0);
      rd(`USIC_ADDR_STA, rv);
      chk("status write", rv, 16'h65E0);
      for (int m = 0; m < 4; m++) begin
         wr(`USIC_ADDR_STA, 16'h0400 | {1'b0, m[1], 8'h00, m[0], 5'h00});
         repeat (3) @(negedge clk_sys);
         chk("idle level", {15'h0000, serial_tx_pin}, {15'h0000, m[1] ~^ m[0]});
      end
      wr(`USIC_ADDR_STA, 16'h0400);
      repeat (400) @(posedge clk_sys);
      $display("test status and idle done");
      wr(`USIC_ADDR_IRQ_MASK, 16'h0001);
      foreach (tx_codes[j]) begin
         wr(`USIC_ADDR_STA, {tx_codes[j][1], 1'b0, tx_codes[j][0], 13'h0400});
         peer.got_q.delete();
         peer.n_got = 0;
         sent_q.delete();
         for (int k = 0; k < 6; k++) begin
            b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
            if (k < 5) sent_q.push_back(b);
            wr(`USIC_ADDR_TXDATA, {8'h00, b});
            if (k == 4) rd(`USIC_ADDR_STA, rv);
         end
         chk("tx full", rv & 16'h0300, 16'h0200);
         wr(`USIC_ADDR_IRQ_STAT, 16'h0003);
         for (int ph = 0; ph < 3; ph++) begin
            wait_rx(ph == 0 ? 1 : ph + 3);
            chk("tx irq", {15'h0000, irq}, {15'h0000, exp_tx_irq(tx_codes[j], ph)});
            wr(`USIC_ADDR_IRQ_STAT, 16'h0001);
         end
         rd(`USIC_ADDR_STA, rv);
         chk("tx idle", rv & 16'h0300, 16'h0100);
         chk("tx count", 16'(peer.n_got), 16'd5);
         for (int k = 0; k < 5; k++) chk("tx byte", {8'h00, peer.got_q[k]}, {8'h00, sent_q[k]});
      end
      $display("test transmit modes done");
      max_low = 0;
      wr(`USIC_ADDR_STA, 16'h0C00);
      rd(`USIC_ADDR_STA, rv);
      chk("break pending", rv & 16'h0800, 16'h0800);
      repeat (300) @(posedge clk_sys);
      chk("break length", 16'(max_low), 16'((`USIC_BREAK_ZEROS + 1) * 16));
      rd(`USIC_ADDR_STA, rv);
      chk("break done", rv, 16'h0500);
      $display("test break done");
      for (int k = 0; k < 3; k++) wr(`USIC_ADDR_TXDATA, {8'h00, 8'($urandom)});
      repeat (40) @(posedge clk_sys);
      wr(`USIC_ADDR_STA, 16'h0000);
      rd(`USIC_ADDR_STA, rv);
      chk("abort status", rv, 16'h0100);
      chk("pin owner off", {15'h0000, tx_pin_owned}, 16'h0000);
      wr(`USIC_ADDR_STA, 16'h0400);
      rd(`USIC_ADDR_STA, rv);
      chk("buffer reset", rv, 16'h0500);
      chk("pin owner on", {15'h0000, tx_pin_owned}, 16'h0001);
      $display("test abort done");
      wr(`USIC_ADDR_IRQ_MASK, 16'h0002);
      for (int c = 0; c < 4; c++) begin
         wr(`USIC_ADDR_STA, {8'h04, c[1:0], 6'h00});
         sent_q.delete();
         for (int n = 1; n < 5; n++) begin
            b = 8'($urandom);
            sent_q.push_back(b);
            peer.send_byte(b);
            repeat (24) @(negedge clk_sys);
            chk("rx irq", {15'h0000, irq}, {15'h0000, exp_rx_irq(c[1:0], n)});
            wr(`USIC_ADDR_IRQ_STAT, 16'h0002);
         end
         for (int n = 0; n < 5; n++) begin
            rd(`USIC_ADDR_RXDATA, rv);
            chk("rx byte", rv, n < 4 ? {8'h00, sent_q[n]} : 16'h0000);
         end
      end
      wr(`USIC_ADDR_STA, 16'h0400);
      peer.send_byte(8'hA5);
      repeat (24) @(negedge clk_sys);
      wr(`USIC_ADDR_IRQ_MASK, 16'h0000);
      @(negedge clk_sys);
      chk("masked irq", {15'h0000, irq}, 16'h0000);
      rd(`USIC_ADDR_IRQ_STAT, rv);
      chk("irq status", rv, 16'h0003);
      wr(`USIC_ADDR_IRQ_STAT, 16'h0003);
      rd(`USIC_ADDR_IRQ_STAT, rv);
      chk("irq cleared", rv, 16'h0000);
      $display("test receive modes done");
      give_verdict;
   end
endmodule // tb
`default_nettype wire
